// [shared/ist_pkg.sv]
// Constants and types shared by the two-wire slave port
package ist_pkg;
   localparam logic [3:0] IST_LAST_BIT = 4'h8;
   localparam logic [3:0] IST_ACK_BIT = 4'h9;
   localparam logic [3:0] IST_CNT_RESET = 4'h0;
   localparam logic [4:0] IST_TEN_HDR = 5'h1E;
   localparam logic [7:0] IST_BYTE_RESET = 8'h00;
   // Software events, carried across as toggles
   localparam int IST_EV_WR = 0;
   localparam int IST_EV_RD = 1;
   localparam int IST_EV_CKP = 2;
   localparam int IST_EV_ADDR = 3;
   localparam int IST_EV_IRQC = 4;
   localparam int IST_EV_BCLC = 5;
   localparam int IST_EV_N = 6;
   // Configuration levels
   localparam int IST_CF_TEN = 0;
   localparam int IST_CF_ADDRESS_HOLD_ENABLE = 1;
   localparam int IST_CF_DATA_HOLD_ENABLE = 2;
   localparam int IST_CF_SEN = 3;
   localparam int IST_CF_SLAVE_COLLISION_DETECT_ENABLE = 4;
   localparam int IST_CF_ACK_VALUE_SELECT = 5;
   localparam int IST_CF_N = 6;
   // Status levels returned to the system clock
   localparam int IST_ST_IRQ = 0;
   localparam int IST_ST_BCL = 1;
   localparam int IST_ST_BF = 2;
   localparam int IST_ST_CKP = 3;
   localparam int IST_ST_UA = 4;
   localparam int IST_ST_RACK = 5;
   localparam int IST_ST_RW = 6;
   localparam int IST_ST_ACKT = 7;
   localparam int IST_ST_BTGL = 8;
   localparam int IST_ST_N = 9;
   typedef enum logic [2:0] {
      IST_IDLE = 3'b000,
      IST_ADDR = 3'b001,
      IST_ACK = 3'b010,
      IST_TX = 3'b011,
      IST_RX = 3'b100
   } ist_state_t;
endpackage

// [src/ist_slave.sv]
// Two-wire slave port: read transfers, collision check, 10-bit addressing
// Overview of operation
// - Read address match: status, buffer, acknowledge
// - After read acknowledge, release bit cleared
// - Buffer write loads shifter; software releases
// - Data shifted out on falling clock edges
// - Master acknowledge latched on ninth rise
// - Not-acknowledge ends transfer, device idles
// - Interrupt flag set on ninth falling edge
// - Collision while sending sets flag, idles
// - After not-acknowledge: no stretch, flag set
// - Address hold: stretch, flag before acknowledge
// - Software picks ack value, device drives it
// - Read acknowledge clears release, sets flag
// - Buffer read clears full; write sets it
// - 10-bit header write match: update flag
// - Address register write releases clock stretched by update flag
// - Low byte mismatch: flags set, buffer untouched
// - Stretch enable holds clock after bytes
// - 10-bit hold behaves exactly as 7-bit
// - Header compares 11110, A9, A8, write
// - Update flag stretches; address write releases
// - Clock held only once seen low
`timescale 1ns/1ps
module ist_slave (
   input wire logic clk,
   input wire logic reset,
   input wire logic bus_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic buf_wr,
   input wire logic [7:0] buf_wdata,
   input wire logic buf_rd,
   input wire logic clock_release_set,
   input wire logic addr_wr,
   input wire logic [7:0] addr_wdata,
   input wire logic irq_clear,
   input wire logic collision_clear,
   input wire logic ten_bit_mode,
   input wire logic address_hold_enable,
   input wire logic data_hold_enable,
   input wire logic stretch_enable,
   input wire logic slave_collision_detect_enable,
   input wire logic ack_value_select,
   output logic serial_irq_flag,
   output logic bus_collision_flag,
   output logic buffer_full,
   output logic clock_hold_release,
   output logic update_address_flag,
   output logic received_ack_status,
   output logic read_status,
   output logic ack_time_status,
   output logic [7:0] transfer_buffer
);
   // System clock side
   logic [ist_pkg::IST_EV_N-1:0] ev_tgl_reg;
   logic [7:0] wdata_hold_reg;
   logic [7:0] addr_hold_reg;
   logic [ist_pkg::IST_ST_N-1:0] st_meta_reg;
   logic [ist_pkg::IST_ST_N-1:0] st_sync_reg;
   logic btgl_d_reg;
   logic [7:0] rdata_reg;
   // Bus clock side
   logic rst_meta_reg;
   logic link_rst;
   logic scl_meta_reg, scl_s, scl_d;
   logic sda_meta_reg, sda_s, sda_d;
   logic [ist_pkg::IST_EV_N-1:0] ev_meta_reg, ev_s_reg, ev_d_reg, ev;
   logic [ist_pkg::IST_CF_N-1:0] cf_meta_reg, cf;
   ist_pkg::ist_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] rx_shift_reg, tx_shift_reg, rx_buf_reg, addr_reg;
   logic irq_reg, bcl_reg, bf_reg, ckp_reg, ua_reg, rack_reg, rw_reg;
   logic ack_time_status_reg, btgl_reg, hold_ack_reg, nack_reg, data_phase_reg;
   logic low_phase_reg, ten_ok_reg, hold_reg, sda_drv_reg;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic addr_hit, eff_nack, last_fall, ack_fall;

   function automatic logic hdr_match(input logic [7:0] b,
                                      input logic [7:0] a);
      hdr_match = (b[7:3] == ist_pkg::IST_TEN_HDR) && (b[2:1] == a[2:1]);
   endfunction

   // Software pulses become toggles; data words stay put until taken
   always_ff @(posedge clk) begin
      if (reset) begin
         ev_tgl_reg <= '0;
         wdata_hold_reg <= ist_pkg::IST_BYTE_RESET;
         addr_hold_reg <= ist_pkg::IST_BYTE_RESET;
      end else begin
         ev_tgl_reg <= ev_tgl_reg ^ {collision_clear, irq_clear, addr_wr,
                                     clock_release_set, buf_rd, buf_wr};
         if (buf_wr) begin
            wdata_hold_reg <= buf_wdata;
         end
         if (addr_wr) begin
            addr_hold_reg <= addr_wdata;
         end
      end
   end

   // Status back to the system clock; buffer word taken on its toggle
   always_ff @(posedge clk) begin
      if (reset) begin
         st_meta_reg <= '0;
         st_sync_reg <= '0;
         btgl_d_reg <= 1'b0;
         rdata_reg <= ist_pkg::IST_BYTE_RESET;
      end else begin
         st_meta_reg <= {btgl_reg, ack_time_status_reg, rw_reg, rack_reg, ua_reg,
                         ckp_reg, bf_reg, bcl_reg, irq_reg};
         st_sync_reg <= st_meta_reg;
         btgl_d_reg <= st_sync_reg[ist_pkg::IST_ST_BTGL];
         if (btgl_d_reg != st_sync_reg[ist_pkg::IST_ST_BTGL]) begin
            rdata_reg <= rx_buf_reg;
         end
      end
   end

   assign serial_irq_flag = st_sync_reg[ist_pkg::IST_ST_IRQ];
   assign bus_collision_flag = st_sync_reg[ist_pkg::IST_ST_BCL];
   assign buffer_full = st_sync_reg[ist_pkg::IST_ST_BF];
   assign clock_hold_release = st_sync_reg[ist_pkg::IST_ST_CKP];
   assign update_address_flag = st_sync_reg[ist_pkg::IST_ST_UA];
   assign received_ack_status = st_sync_reg[ist_pkg::IST_ST_RACK];
   assign read_status = st_sync_reg[ist_pkg::IST_ST_RW];
   assign ack_time_status = st_sync_reg[ist_pkg::IST_ST_ACKT];
   assign transfer_buffer = rdata_reg;

   // Reset and inputs into the bus clock, two flops each
   always_ff @(posedge bus_clk) begin
      rst_meta_reg <= reset;
      link_rst <= rst_meta_reg;
      scl_meta_reg <= scl_i;
      scl_s <= scl_meta_reg;
      scl_d <= scl_s;
      sda_meta_reg <= sda_i;
      sda_s <= sda_meta_reg;
      sda_d <= sda_s;
      ev_meta_reg <= ev_tgl_reg;
      ev_s_reg <= ev_meta_reg;
      ev_d_reg <= ev_s_reg;
      cf_meta_reg <= {ack_value_select, slave_collision_detect_enable,
                      stretch_enable, data_hold_enable,
                      address_hold_enable, ten_bit_mode};
      cf <= cf_meta_reg;
   end

   assign ev = link_rst ? '0 : (ev_s_reg ^ ev_d_reg);
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   assign last_fall = scl_fall && (cnt_reg == ist_pkg::IST_LAST_BIT);
   assign ack_fall = scl_fall && (cnt_reg == ist_pkg::IST_ACK_BIT);
   assign eff_nack = hold_ack_reg ? cf[ist_pkg::IST_CF_ACK_VALUE_SELECT] : nack_reg;

   // Header needs a prior full match before a read is accepted
   always_comb begin
      if (!cf[ist_pkg::IST_CF_TEN]) begin
         addr_hit = rx_shift_reg[7:1] == addr_reg[7:1];
      end else if (low_phase_reg) begin
         addr_hit = rx_shift_reg == addr_reg;
      end else begin
         addr_hit = hdr_match(rx_shift_reg, addr_reg)
                    && (!rx_shift_reg[0] || ten_ok_reg);
      end
   end

   // Protocol engine; software clears come first so hardware sets win
   always_ff @(posedge bus_clk) begin
      if (link_rst) begin
         state_reg <= ist_pkg::IST_IDLE;
         cnt_reg <= ist_pkg::IST_CNT_RESET;
         rx_shift_reg <= ist_pkg::IST_BYTE_RESET;
         tx_shift_reg <= ist_pkg::IST_BYTE_RESET;
         rx_buf_reg <= ist_pkg::IST_BYTE_RESET;
         addr_reg <= ist_pkg::IST_BYTE_RESET;
         {irq_reg, bcl_reg, bf_reg, ua_reg, rack_reg, rw_reg} <= '0;
         {ack_time_status_reg, btgl_reg, hold_ack_reg, nack_reg} <= '0;
         {data_phase_reg, low_phase_reg, ten_ok_reg} <= '0;
         ckp_reg <= 1'b1;
      end else begin
         if (ev[ist_pkg::IST_EV_RD]) begin
            bf_reg <= 1'b0;
         end
         if (ev[ist_pkg::IST_EV_WR]) begin
            tx_shift_reg <= wdata_hold_reg;
            bf_reg <= 1'b1;
         end
         if (ev[ist_pkg::IST_EV_ADDR]) begin
            addr_reg <= addr_hold_reg;
            ua_reg <= 1'b0;
         end
         if (ev[ist_pkg::IST_EV_IRQC]) begin
            irq_reg <= 1'b0;
         end
         if (ev[ist_pkg::IST_EV_BCLC]) begin
            bcl_reg <= 1'b0;
         end
         if (stop_cond) begin
            state_reg <= ist_pkg::IST_IDLE;
            ten_ok_reg <= 1'b0;
            low_phase_reg <= 1'b0;
         end else if (start_cond) begin
            state_reg <= ist_pkg::IST_ADDR;
            cnt_reg <= ist_pkg::IST_CNT_RESET;
            low_phase_reg <= 1'b0;
            data_phase_reg <= 1'b0;
         end else begin
            unique case (state_reg)
               ist_pkg::IST_IDLE: begin
               end
               ist_pkg::IST_ADDR, ist_pkg::IST_RX: begin
                  if (scl_rise) begin
                     rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  if (last_fall && state_reg == ist_pkg::IST_RX) begin
                     state_reg <= ist_pkg::IST_ACK;
                     data_phase_reg <= 1'b1;
                     nack_reg <= bf_reg;
                     hold_ack_reg <= cf[ist_pkg::IST_CF_DATA_HOLD_ENABLE];
                     if (cf[ist_pkg::IST_CF_DATA_HOLD_ENABLE]) begin
                        ckp_reg <= 1'b0;
                        irq_reg <= 1'b1;
                        ack_time_status_reg <= 1'b1;
                     end
                     if (!bf_reg) begin
                        rx_buf_reg <= rx_shift_reg;
                        bf_reg <= 1'b1;
                        btgl_reg <= ~btgl_reg;
                     end
                  end else if (last_fall && addr_hit) begin
                     state_reg <= ist_pkg::IST_ACK;
                     data_phase_reg <= 1'b0;
                     rw_reg <= rx_shift_reg[0] & ~low_phase_reg;
                     rx_buf_reg <= rx_shift_reg;
                     bf_reg <= 1'b1;
                     btgl_reg <= ~btgl_reg;
                     nack_reg <= 1'b0;
                     hold_ack_reg <= cf[ist_pkg::IST_CF_ADDRESS_HOLD_ENABLE];
                     if (cf[ist_pkg::IST_CF_ADDRESS_HOLD_ENABLE]) begin
                        ckp_reg <= 1'b0;
                        irq_reg <= 1'b1;
                        ack_time_status_reg <= 1'b1;
                     end
                  end else if (last_fall) begin
                     // Unmatched low byte still reports; others are silent
                     state_reg <= ist_pkg::IST_IDLE;
                     if (low_phase_reg) begin
                        irq_reg <= 1'b1;
                        ua_reg <= 1'b1;
                        low_phase_reg <= 1'b0;
                     end
                  end
               end
               ist_pkg::IST_ACK: begin
                  if (scl_rise) begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  if (ack_fall) begin
                     ack_time_status_reg <= 1'b0;
                     cnt_reg <= ist_pkg::IST_CNT_RESET;
                     if (eff_nack) begin
                        state_reg <= ist_pkg::IST_IDLE;
                        low_phase_reg <= 1'b0;
                     end else if (!data_phase_reg && rw_reg) begin
                        ckp_reg <= 1'b0;
                        irq_reg <= 1'b1;
                        state_reg <= ist_pkg::IST_TX;
                     end else if (!data_phase_reg && cf[ist_pkg::IST_CF_TEN]
                                  && !low_phase_reg) begin
                        ua_reg <= 1'b1;
                        irq_reg <= 1'b1;
                        low_phase_reg <= 1'b1;
                        state_reg <= ist_pkg::IST_ADDR;
                     end else begin
                        if (!data_phase_reg && cf[ist_pkg::IST_CF_TEN]) begin
                           ua_reg <= 1'b1;
                           ten_ok_reg <= 1'b1;
                           low_phase_reg <= 1'b0;
                        end
                        irq_reg <= 1'b1;
                        if (cf[ist_pkg::IST_CF_SEN]) begin
                           ckp_reg <= 1'b0;
                        end
                        data_phase_reg <= 1'b1;
                        state_reg <= ist_pkg::IST_RX;
                     end
                  end
               end
               ist_pkg::IST_TX: begin
                  if (scl_rise) begin
                     cnt_reg <= cnt_reg + 4'h1;
                     if (cnt_reg == ist_pkg::IST_LAST_BIT) begin
                        rack_reg <= sda_s;
                     end
                     if (cnt_reg < ist_pkg::IST_LAST_BIT && tx_shift_reg[7]
                         && !sda_s && cf[ist_pkg::IST_CF_SLAVE_COLLISION_DETECT_ENABLE]) begin
                        bcl_reg <= 1'b1;
                        state_reg <= ist_pkg::IST_IDLE;
                     end
                  end
                  if (scl_fall && cnt_reg != ist_pkg::IST_CNT_RESET
                      && cnt_reg < ist_pkg::IST_LAST_BIT) begin
                     tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                  end
                  if (ack_fall) begin
                     irq_reg <= 1'b1;
                     cnt_reg <= ist_pkg::IST_CNT_RESET;
                     if (rack_reg) begin
                        state_reg <= ist_pkg::IST_IDLE;
                     end else begin
                        ckp_reg <= 1'b0;
                     end
                  end
               end
               default: begin
                  state_reg <= ist_pkg::IST_IDLE;
               end
            endcase
         end
         // Software release beats a hardware clear in the same cycle
         if (ev[ist_pkg::IST_EV_CKP]) begin
            ckp_reg <= 1'b1;
         end
      end
   end

   // Pin drivers; the clock is grabbed only once it is already low
   always_ff @(posedge bus_clk) begin
      if (link_rst) begin
         hold_reg <= 1'b0;
         sda_drv_reg <= 1'b0;
      end else begin
         if (!ckp_reg || ua_reg) begin
            hold_reg <= hold_reg | ~scl_s;
         end else begin
            hold_reg <= 1'b0;
         end
         // Last bit held through its high phase, let go at the fall
         sda_drv_reg <= (state_reg == ist_pkg::IST_ACK && !eff_nack)
                        || (state_reg == ist_pkg::IST_TX
                            && (cnt_reg < ist_pkg::IST_LAST_BIT
                                || (cnt_reg == ist_pkg::IST_LAST_BIT
                                    && scl_s && scl_d))
                            && !tx_shift_reg[7]);
      end
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = hold_reg;
   assign sda_oe = sda_drv_reg;

   default clocking cb @(posedge bus_clk); endclocking
   default disable iff (link_rst);

   scl_grab_safe_a: assert property (
      $rose(hold_reg) |-> !$past(scl_s))
      else $error("clock grabbed while high");
   read_stretch_a: assert property (state_reg == ist_pkg::IST_ACK
      && ack_fall && !eff_nack && !data_phase_reg && rw_reg && !start_cond
      && !stop_cond && !ev[ist_pkg::IST_EV_CKP]
      |=> !ckp_reg && irq_reg && state_reg == ist_pkg::IST_TX ##1 hold_reg)
      else $error("no stretch after read acknowledge");
   nack_idle_a: assert property (
      state_reg == ist_pkg::IST_TX && ack_fall
      && rack_reg && !start_cond && !stop_cond
      |=> state_reg == ist_pkg::IST_IDLE && irq_reg)
      else $error("not-acknowledge did not end transfer");
   ack_latch_a: assert property (
      state_reg == ist_pkg::IST_TX && scl_rise
      && cnt_reg == ist_pkg::IST_LAST_BIT && !start_cond && !stop_cond
      |=> rack_reg == $past(sda_s))
      else $error("master acknowledge not latched");
   collision_flag_a: assert property (
      state_reg == ist_pkg::IST_TX
      && scl_rise && cnt_reg < ist_pkg::IST_LAST_BIT && tx_shift_reg[7]
      && !sda_s && cf[ist_pkg::IST_CF_SLAVE_COLLISION_DETECT_ENABLE] && !start_cond && !stop_cond
      |=> bcl_reg && state_reg == ist_pkg::IST_IDLE ##1 !sda_drv_reg)
      else $error("collision not handled");
   buf_full_set_a: assert property (
      ev[ist_pkg::IST_EV_WR] |=> bf_reg)
      else $error("buffer full not set by write");
   ua_release_a: assert property (
      ev[ist_pkg::IST_EV_ADDR] && ckp_reg
      && !ev[ist_pkg::IST_EV_CKP] ##1 ckp_reg |-> !ua_reg ##1 !hold_reg)
      else $error("address write did not release clock");
   addr_hold_a: assert property (
      state_reg == ist_pkg::IST_ADDR && last_fall
      && addr_hit && cf[ist_pkg::IST_CF_ADDRESS_HOLD_ENABLE] && !start_cond && !stop_cond
      && !ev[ist_pkg::IST_EV_CKP] |=> !ckp_reg && irq_reg && ack_time_status_reg)
      else $error("address hold did not stretch");
   tx_stable_a: assert property (
      state_reg == ist_pkg::IST_TX && scl_s
      && scl_d && !ev[ist_pkg::IST_EV_WR] && !start_cond ##1 scl_s
      |-> $stable(tx_shift_reg))
      else $error("transmit data changed while clock high");

   read_done_c: cover property (state_reg == ist_pkg::IST_TX && ack_fall
      && rack_reg);
   ten_bit_c: cover property ($rose(ua_reg) ##[1:1000] $fell(ua_reg));
   collision_c: cover property ($rose(bcl_reg));
   rx_byte_c: cover property (state_reg == ist_pkg::IST_RX && last_fall);
endmodule // ist_slave

// [tb/ist_master_model.sv]
// Behavioural two-wire bus master with open-drain outputs
`timescale 1ns/1ps
module ist_master_model (
   output logic scl_low,
   output logic sda_low,
   input wire logic scl,
   input wire logic sda
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Bounded wait, so a slave that never lets go cannot hang us
   task automatic rise();
      int k;
      scl_low = 1'b0;
      for (k = 0; k < 5000 && scl !== 1'b1; k++) #10;
      #200;
   endtask
   // SDA moves well after SCL fell, never near a high phase
   task automatic bitx(input logic b, output logic r);
      #50;
      sda_low = !b;
      #150;
      rise();
      r = sda;
      scl_low = 1'b1;
   endtask
   task automatic start();
      sda_low = 1'b1;
      #200;
      scl_low = 1'b1;
   endtask
   task automatic stop();
      #50;
      sda_low = 1'b1;
      #150;
      rise();
      sda_low = 1'b0;
      #200;
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      int k;
      for (k = 7; k >= 0; k--) bitx(d[k], r);
      bitx(1'b1, ack);
   endtask
   // Clash pulls SDA low over the slave's bits to force a collision
   task automatic rd(input logic nack, input logic clash,
                     output logic [7:0] d);
      logic r;
      int k;
      for (k = 7; k >= 0; k--) bitx(!clash, d[k]);
      bitx(nack, r);
   endtask
endmodule // ist_master_model

// [tb/test_i2c_slave_tx_and_10bit_rx.sv]
// Self-checking bench: reads, holds, collisions, 10-bit addressing
`timescale 1ns/1ps
module test_i2c_slave_tx_and_10bit_rx;
   logic clk, reset, bus_clk, m_scl, m_sda, scl_oe, sda_oe, ack;
   logic buf_wr, buf_rd, clock_release_set, addr_wr, irq_clear;
   logic collision_clear, ten_bit_mode, address_hold_enable;
   logic stretch_enable, slave_collision_detect_enable, data_hold_enable;
   logic ack_value_select, serial_irq_flag, bus_collision_flag;
   logic buffer_full, clock_hold_release, update_address_flag;
   logic received_ack_status, read_status, ack_time_status;
   logic [7:0] buf_wdata, addr_wdata, transfer_buffer, adr, dat, got;
   int fail_count, n_tests, i;
   wire logic scl_w = !(m_scl || scl_oe);
   wire logic sda_w = !(m_sda || sda_oe);
   wire logic [7:0] st = {serial_irq_flag, bus_collision_flag,
      buffer_full, clock_hold_release, update_address_flag,
      received_ack_status, read_status, ack_time_status};
   ist_slave u_dut (.clk, .reset, .bus_clk, .scl_i(scl_w), .scl_o(),
      .scl_oe, .sda_i(sda_w), .sda_o(), .sda_oe, .buf_wr, .buf_wdata,
      .buf_rd, .clock_release_set, .addr_wr, .addr_wdata, .irq_clear,
      .collision_clear, .ten_bit_mode, .address_hold_enable,
      .data_hold_enable, .stretch_enable,
      .slave_collision_detect_enable, .ack_value_select,
      .serial_irq_flag, .bus_collision_flag, .buffer_full,
      .clock_hold_release, .update_address_flag, .received_ack_status,
      .read_status, .ack_time_status, .transfer_buffer);
   ist_master_model u_m (.scl_low(m_scl), .sda_low(m_sda), .scl(scl_w),
      .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      bus_clk = 1'b0;
      #3.1;
      forever #7.5 bus_clk = ~bus_clk;
   end
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Status crosses two clock domains, so give it time to land
   task automatic nap();
      repeat (30) @(negedge clk);
   endtask
   function automatic logic [7:0] tx_status(input logic nack);
      return nack ? 8'h94 : 8'h80;
   endfunction
   task automatic sw(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      nap();
   endtask
   task automatic wirq();
      int k;
      for (k = 0; k < 4000 && serial_irq_flag !== 1'b1; k++)
         @(negedge clk);
      nap();
   endtask
   task automatic txbyte(logic nack, logic clash);
      dat = 8'($urandom) | {clash, 7'h00};
      buf_wdata = dat;
      sw(buf_wr);
      chk("bf_wr", 8'h01, buffer_full);
      sw(clock_release_set);
      u_m.rd(nack, clash, got);
      nap();
      if (!clash) chk("tx_data", dat, got);
   endtask
   task print_verdict();
      $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h3491FFCF));
      {buf_wr, buf_rd, clock_release_set, addr_wr, irq_clear} = '0;
      {collision_clear, ten_bit_mode, address_hold_enable} = '0;
      {stretch_enable, slave_collision_detect_enable, data_hold_enable} = '0;
      {ack_value_select, buf_wdata, addr_wdata} = '0;
      fail_count = 0;
      n_tests = 0;
      reset = 1'b1;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      nap();
      chk("rst", 8'h10, st);
      adr = 8'($urandom) & 8'hFE;
      addr_wdata = adr;
      sw(addr_wr);
      u_m.start();
      u_m.wr(adr | 8'h01, ack);
      nap();
      chk("rd_ack", 8'h00, ack);
      chk("rd_buf", adr | 8'h01, transfer_buffer);
      chk("rd_st", 8'hA2, st);
      chk("rd_hold", 8'h01, scl_oe);
      sw(irq_clear);
      sw(buf_rd);
      chk("bf_rd", 8'h00, buffer_full);
      for (i = 0; i < 4; i++) begin
         txbyte(i == 3, 1'b0);
         chk("tx_st", tx_status(i == 3), st & 8'h94);
         chk("tx_hold", i != 3, scl_oe);
         sw(irq_clear);
      end
      u_m.stop();
      u_m.start();
      u_m.wr(adr ^ 8'h10, ack);
      nap();
      chk("miss", 8'h01, {serial_irq_flag, ack});
      u_m.stop();
      // Address hold: software picks acknowledge, then not-acknowledge
      address_hold_enable = 1'b1;
      for (i = 0; i < 2; i++) begin
         ack_value_select = i[0];
         u_m.start();
         fork
            u_m.wr(adr | 8'h01, ack);
            begin
               wirq();
               chk("ah_st", 8'h81, st & 8'h91);
               sw(irq_clear);
               sw(buf_rd);
               sw(clock_release_set);
            end
         join
         nap();
         chk("ah_ack", i[0], ack);
         chk("ah_end", i ? 8'h10 : 8'h80, st & 8'h91);
         sw(irq_clear);
         if (i == 0) txbyte(1'b1, 1'b0);
         sw(irq_clear);
         u_m.stop();
      end
      address_hold_enable = 1'b0;
      slave_collision_detect_enable = 1'b1;
      u_m.start();
      u_m.wr(adr | 8'h01, ack);
      nap();
      sw(irq_clear);
      sw(buf_rd);
      txbyte(1'b1, 1'b1);
      chk("bcl", 8'h01, {scl_oe, bus_collision_flag});
      sw(collision_clear);
      sw(irq_clear);
      u_m.stop();
      slave_collision_detect_enable = 1'b0;
      ten_bit_mode = 1'b1;
      adr = {5'h1E, 2'($urandom), 1'b0};
      dat = 8'($urandom);
      addr_wdata = adr;
      sw(addr_wr);
      for (i = 0; i < 2; i++) begin
         u_m.start();
         u_m.wr(adr, ack);
         nap();
         chk("hdr", 8'h98, st & 8'h98);
         chk("hdr_hold", 8'h01, {ack, scl_oe});
         sw(irq_clear);
         sw(buf_rd);
         addr_wdata = dat;
         sw(addr_wr);
         chk("ua_rel", 8'h00, {update_address_flag, scl_oe});
         // A mismatch stretches the ninth clock until the header is back
         fork
            u_m.wr(i ? dat : ~dat, ack);
            begin
               wirq();
               chk("low", i ? 8'hB8 : 8'h98, st & 8'hB8);
               chk("low_hold", 8'h01, scl_oe);
               sw(irq_clear);
               sw(buf_rd);
               addr_wdata = adr;
               sw(addr_wr);
            end
         join
         nap();
         chk("low_ack", !i, ack);
         if (i == 1) begin
            stretch_enable = 1'b1;
            data_hold_enable = 1'b1;
            ack_value_select = 1'b0;
            got = 8'($urandom);
            fork
               u_m.wr(got, ack);
               begin
                  wirq();
                  chk("dh_st", 8'h81, st & 8'h91);
                  sw(irq_clear);
                  sw(clock_release_set);
               end
            join
            nap();
            chk("rx", got, transfer_buffer);
            chk("rx_hold", 8'h01, {ack, clock_hold_release, scl_oe});
            sw(irq_clear);
            sw(buf_rd);
            sw(clock_release_set);
         end
         u_m.stop();
      end
      print_verdict();
   end
endmodule // test_i2c_slave_tx_and_10bit_rx
